//--- hdl/pdec_ctrl.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module pdec_ctrl
   import pdec_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   // Wishbone slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [15:0] wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic [31:0]      wb_dat_out,
   output logic             wb_ack_out,
   output logic             wb_err_out,
   // CPU instruction side
   input  wire logic        instr_valid_in,
   input  wire logic [31:0] instr_word_in,
   input  wire logic        instr_done_in,
   output logic             instr_skip_out,
   // Pins
   input  wire logic        nmi_n_in,
   input  wire logic [3:0]  fast_ext_irq_pin_in,
   input  wire logic        stab_done_in,
   // Power control
   output logic             clk_freeze_out,
   output logic             osc_pll_stop_out,
   output logic             wdt_halt_out,
   output logic             rc_discharge_out,
   output logic [3:0]       channel_irq_request_flag_out,
   output logic             irq_out
);
   logic [15:0]          fast_irq_edge_select_q;
   logic [15:0]          system_config_reg_q;
   logic [3:0]           channel_irq_enable_q;
   logic [3:0]           req_flag_q;
   logic [PDEC_NEV-1:0]  irq_stat_q;
   logic [PDEC_NEV-1:0]  irq_mask_q;
   logic [PDEC_NEV-1:0]  ev_set;
   logic [3:0]           pin_ref_q;
   logic [3:0]           pin_q;
   logic [3:0]           blocks;
   logic [3:0]           wakes;
   logic [3:0]           edge_hit;
   logic [3:0]           flag_set;
   logic                 pd_variant_select;
   logic                 power_down_instruction;
   logic                 entry_ok;
   logic                 pending_q;
   logic                 ack_q;
   logic                 acc;
   logic                 wr;
   logic                 hit;
   pdec_state_t          state_q;
   pdec_state_t          state_d;

   assign pd_variant_select = system_config_reg_q[PDEC_VARIANT_BIT];
   // Only the full 32-bit opcode counts
   assign power_down_instruction = instr_valid_in &
      (instr_word_in == PDEC_POWER_DOWN_INSTRUCTION_OP);

   genvar gi;
   generate
      for (gi = 0; gi < PDEC_NPINS; gi++) begin : g_pin
         pdec_pin_eval u_eval (
            .es_in            (fast_irq_edge_select_q[gi*2 +: 2]),
            .pin_in           (fast_ext_irq_pin_in[gi]),
            .pin_ref_in       (pin_ref_q[gi]),
            .blocks_entry_out (blocks[gi]),
            .wakes_out        (wakes[gi])
         );
         always_comb begin
            case (fast_irq_edge_select_q[gi*2 +: 2])
               PDEC_ES_RISE: edge_hit[gi] = fast_ext_irq_pin_in[gi] &
                                            ~pin_q[gi];
               PDEC_ES_FALL: edge_hit[gi] = ~fast_ext_irq_pin_in[gi] &
                                            pin_q[gi];
               PDEC_ES_ANY:  edge_hit[gi] = fast_ext_irq_pin_in[gi] ^
                                            pin_q[gi];
               default:      edge_hit[gi] = 1'b0;
            endcase
         end
      end
   endgenerate

   // Entry condition per variant
   always_comb begin
      if (!pd_variant_select) begin
         entry_ok = ~nmi_n_in;
      end else begin
         entry_ok = ~|blocks;
      end
   end

   // Power state sequence
   always_comb begin
      state_d = state_q;
      case (state_q)
         PDEC_RUN: begin
            if (power_down_instruction && entry_ok) begin
               state_d = PDEC_DRAIN;
            end
         end
         PDEC_DRAIN: begin
            if (instr_done_in) begin
               state_d = PDEC_PD;
            end
         end
         PDEC_PD: begin
            if (pd_variant_select && |wakes) begin
               state_d = PDEC_STAB;
            end
         end
         PDEC_STAB: begin
            if (stab_done_in) begin
               state_d = PDEC_RUN;
            end
         end
         default: state_d = PDEC_RUN;
      endcase
   end

   // Reset is the only exit in the protected variant
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= PDEC_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Pin level captured when power down is entered
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_ref_q <= 4'h0;
         pin_q     <= 4'h0;
      end else begin
         pin_q <= fast_ext_irq_pin_in;
         if (state_q == PDEC_DRAIN) begin
            pin_ref_q <= fast_ext_irq_pin_in;
         end
      end
   end

   assign clk_freeze_out   = (state_q == PDEC_PD) ||
                             (state_q == PDEC_STAB);
   assign osc_pll_stop_out = (state_q == PDEC_PD);
   assign wdt_halt_out     = clk_freeze_out;
   assign rc_discharge_out = (state_q == PDEC_STAB);
   assign instr_skip_out   = power_down_instruction &
                             ~entry_ok;

   // Request flags: pin wake or edge sets, software write-one clears
   assign flag_set = edge_hit |
      (((state_q == PDEC_PD) && pd_variant_select) ? wakes : 4'h0);
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         req_flag_q <= 4'h0;
      end else begin
         for (int i = 0; i < PDEC_NPINS; i++) begin
            if (flag_set[i]) begin
               req_flag_q[i] <= 1'b1;
            end else if (wr && wb_adr_in == PDEC_ADR_CHAN_CTL &&
                         wb_sel_in[1] && wb_dat_in[8+i]) begin
               req_flag_q[i] <= 1'b0;
            end
         end
      end
   end
   assign channel_irq_request_flag_out = req_flag_q;

   // Wishbone decode
   // Block a second answer while err is still showing
   assign acc = wb_cyc_in & wb_stb_in & ~ack_q & ~wb_err_out;
   assign wr  = acc & wb_we_in;
   always_comb begin
      case (wb_adr_in)
         PDEC_ADR_EDGE_SEL, PDEC_ADR_SYSCFG, PDEC_ADR_STATUS,
         PDEC_ADR_IRQ_STAT, PDEC_ADR_IRQ_MASK, PDEC_ADR_CHAN_CTL:
            hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // Configuration registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fast_irq_edge_select_q <= PDEC_EDGE_SEL_RST;
         system_config_reg_q    <= PDEC_SYSCFG_RST;
         channel_irq_enable_q   <= 4'h0;
         irq_mask_q             <= '0;
      end else if (wr) begin
         case (wb_adr_in)
            PDEC_ADR_EDGE_SEL: begin
               if (wb_sel_in[0]) begin
                  fast_irq_edge_select_q[7:0] <= wb_dat_in[7:0];
               end
            end
            PDEC_ADR_SYSCFG: begin
               if (wb_sel_in[0]) begin
                  system_config_reg_q[7:0] <= wb_dat_in[7:0];
               end
               if (wb_sel_in[1]) begin
                  system_config_reg_q[15:8] <= wb_dat_in[15:8];
               end
            end
            PDEC_ADR_IRQ_MASK: begin
               if (wb_sel_in[0]) begin
                  irq_mask_q <= wb_dat_in[PDEC_NEV-1:0];
               end
            end
            PDEC_ADR_CHAN_CTL: begin
               if (wb_sel_in[0]) begin
                  channel_irq_enable_q <= wb_dat_in[3:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Sticky events, set wins over clear
   assign ev_set[PDEC_EV_ENTER]    = (state_q == PDEC_DRAIN) &&
                                     instr_done_in;
   assign ev_set[PDEC_EV_PIN_WAKE] = (state_q == PDEC_STAB) &&
                                     stab_done_in;
   assign ev_set[PDEC_EV_REJECT]   = instr_skip_out;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_stat_q <= '0;
      end else begin
         for (int i = 0; i < PDEC_NEV; i++) begin
            if (ev_set[i]) begin
               irq_stat_q[i] <= 1'b1;
            end else if (wr && wb_adr_in == PDEC_ADR_IRQ_STAT &&
                         wb_sel_in[0] && wb_dat_in[i]) begin
               irq_stat_q[i] <= 1'b0;
            end
         end
      end
   end
   assign irq_out = |(irq_stat_q & irq_mask_q);

   // Answer one cycle after the request
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ack_q      <= 1'b0;
         wb_err_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         ack_q      <= acc & hit;
         wb_err_out <= acc & ~hit;
         wb_dat_out <= 32'h0000_0000;
         if (acc && !wb_we_in) begin
            case (wb_adr_in)
               PDEC_ADR_EDGE_SEL:
                  wb_dat_out[15:0] <= fast_irq_edge_select_q;
               PDEC_ADR_SYSCFG:
                  wb_dat_out[15:0] <= system_config_reg_q;
               PDEC_ADR_STATUS:
                  wb_dat_out[3:0]  <= state_q;
               PDEC_ADR_IRQ_STAT:
                  wb_dat_out[PDEC_NEV-1:0] <= irq_stat_q;
               PDEC_ADR_IRQ_MASK:
                  wb_dat_out[PDEC_NEV-1:0] <= irq_mask_q;
               PDEC_ADR_CHAN_CTL:
                  wb_dat_out[11:0] <= {req_flag_q, 4'h0,
                                       channel_irq_enable_q};
               default: wb_dat_out <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign wb_ack_out = ack_q;
endmodule : pdec_ctrl
`default_nettype wire

//--- hdl/pdec_pin_eval.sv
`timescale 1ns/10ps
`default_nettype none
module pdec_pin_eval
   import pdec_pkg::*;
(
   // Pin and mode
   input  wire logic [1:0] es_in,
   input  wire logic       pin_in,
   input  wire logic       pin_ref_in,
   // Decisions
   output logic            blocks_entry_out,
   output logic            wakes_out
);
   always_comb begin
      blocks_entry_out = 1'b0;
      wakes_out        = 1'b0;
      case (es_in)
         PDEC_ES_OFF: begin
            blocks_entry_out = 1'b0;
            wakes_out        = 1'b0;
         end
         PDEC_ES_RISE: begin
            blocks_entry_out = pin_in;
            wakes_out        = pin_in;
         end
         PDEC_ES_FALL: begin
            blocks_entry_out = ~pin_in;
            wakes_out        = ~pin_in;
         end
         PDEC_ES_ANY: begin
            blocks_entry_out = 1'b0;
            wakes_out        = pin_in ^ pin_ref_in;
         end
         default: begin
            blocks_entry_out = 1'b0;
            wakes_out        = 1'b0;
         end
      endcase
   end
endmodule : pdec_pin_eval
`default_nettype wire

//--- hdl/pdec_pkg.sv
package pdec_pkg;
   // Register byte addresses on the bus
   localparam logic [15:0] PDEC_ADR_EDGE_SEL = 16'hf1c0;
   localparam logic [15:0] PDEC_ADR_SYSCFG   = 16'hf1c4;
   localparam logic [15:0] PDEC_ADR_STATUS   = 16'hf1c8;
   localparam logic [15:0] PDEC_ADR_IRQ_STAT = 16'hf1cc;
   localparam logic [15:0] PDEC_ADR_IRQ_MASK = 16'hf1d0;
   localparam logic [15:0] PDEC_ADR_CHAN_CTL = 16'hf1d4;
   // Reset values
   localparam logic [15:0] PDEC_EDGE_SEL_RST = 16'h0000;
   localparam logic [15:0] PDEC_SYSCFG_RST   = 16'h0000;
   // Field positions
   localparam int PDEC_VARIANT_BIT  = 5;
   localparam int PDEC_NPINS        = 4;
   localparam int PDEC_ES_W         = 2;
   // Event bits of status and mask
   localparam int PDEC_EV_ENTER     = 0;
   localparam int PDEC_EV_PIN_WAKE  = 1;
   localparam int PDEC_EV_REJECT    = 2;
   localparam int PDEC_NEV          = 3;
   // Protected instruction encoding
   localparam logic [31:0] PDEC_POWER_DOWN_INSTRUCTION_OP = 32'ha55a_5aa5;
   // Edge-select codes
   localparam logic [1:0] PDEC_ES_OFF  = 2'h0;
   localparam logic [1:0] PDEC_ES_RISE = 2'h1;
   localparam logic [1:0] PDEC_ES_FALL = 2'h2;
   localparam logic [1:0] PDEC_ES_ANY  = 2'h3;
   // Top-level states, one-hot
   typedef enum logic [3:0] {
      PDEC_RUN   = 4'h1,
      PDEC_DRAIN = 4'h2,
      PDEC_PD    = 4'h4,
      PDEC_STAB  = 4'h8
   } pdec_state_t;
endpackage : pdec_pkg

//--- verification/pdec_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pdec_ctrl_monitor
   import pdec_pkg::*;
(
   // Clock, reset and bus
   input wire logic        clk_in, nrst_in, wb_cyc_in, wb_stb_in,
   input wire logic        wb_we_in, wb_ack_out, wb_err_out,
   input wire logic [15:0] wb_adr_in,
   // Instruction side
   input wire logic        instr_valid_in, instr_done_in, instr_skip_out,
   input wire logic [31:0] instr_word_in,
   // Power control
   input wire logic        stab_done_in, clk_freeze_out, osc_pll_stop_out,
   input wire logic        wdt_halt_out, rc_discharge_out,
   input wire logic [3:0]  channel_irq_request_flag_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   sequence s_req;
      wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
   endsequence
   sequence s_refused;
      instr_skip_out ##1 !clk_freeze_out;
   endsequence
   chk_bus_answer: assert property (s_req |=> wb_ack_out || wb_err_out)
      else $error("bus request not answered in one cycle");
   chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   chk_err_unmapped: assert property (wb_err_out |-> !($past(wb_adr_in)
      inside {[PDEC_ADR_EDGE_SEL:PDEC_ADR_CHAN_CTL]}))
      else $error("error on a mapped address");
   chk_wdt_halt: assert property (wdt_halt_out == clk_freeze_out)
      else $error("watchdog halt differs from freeze");
   chk_enter_done: assert property ($rose(clk_freeze_out)
      |-> $past(instr_done_in)) else $error("entry before completion");
   chk_skip_opcode: assert property (instr_skip_out |->
      instr_valid_in && instr_word_in == PDEC_POWER_DOWN_INSTRUCTION_OP ##0 s_refused)
      else $error("bad refusal");
   chk_stab_hold: assert property (rc_discharge_out && !stab_done_in
      |=> clk_freeze_out) else $error("clocks back before stable");
   chk_stab_release: assert property (rc_discharge_out
      && stab_done_in |=> !clk_freeze_out && !rc_discharge_out)
      else $error("clocks not back after stable");
   chk_wake_osc: assert property ($rose(rc_discharge_out)
      |-> !osc_pll_stop_out && $past(osc_pll_stop_out))
      else $error("wake not from stopped oscillator");
   chk_osc_frozen: assert property (osc_pll_stop_out |->
      clk_freeze_out) else $error("oscillator stopped, clocks running");
   chk_flag_sticky: assert property (|($past(channel_irq_request_flag_out)
      & ~channel_irq_request_flag_out) |-> $past(wb_we_in && wb_stb_in
      && wb_adr_in == PDEC_ADR_CHAN_CTL)) else $error("flag lost");
endmodule : pdec_ctrl_monitor
`default_nettype wire

//--- verification/pdec_rc_model.sv
`timescale 1ns/10ps
`default_nettype none
module pdec_rc_model #(
   parameter int STAB_CYC = 6
) (
   // Clock, reset and discharge
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic rc_discharge_in,
   // Threshold reached
   output logic     stab_done_out
);
   int cnt_q;
   // Capacitor discharges only while pulled down
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) cnt_q <= 0;
      else if (!rc_discharge_in) cnt_q <= 0;
      else if (cnt_q < STAB_CYC) cnt_q <= cnt_q + 1;
   end
   assign stab_done_out = rc_discharge_in && (cnt_q == STAB_CYC);
endmodule : pdec_rc_model
`default_nettype wire

//--- verification/power_down_entry_exit_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module power_down_entry_exit_control_tb;
   import pdec_pkg::*;
   logic        clk_in = 0, nrst_in = 0, cyc = 0, stb = 0, we = 0;
   logic [15:0] adr = 16'h0000;
   logic [31:0] dat = 32'h0000_0000, wrd = 32'h0000_0000, rdat, wbdo;
   logic        vld = 0, done = 0, nmi_n = 1, rd_err, ent;
   logic [3:0]  pins = 4'h0, flags;
   logic        ack, err, skip, frz, osc, wdt, rcd, stab, irq;
   int          err_count = 0, checks_done = 0, n;
   always #10 clk_in = ~clk_in;
   pdec_ctrl dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
      .wb_dat_in(dat), .wb_dat_out(wbdo), .wb_ack_out(ack),
      .wb_err_out(err), .instr_valid_in(vld), .instr_word_in(wrd),
      .instr_done_in(done), .instr_skip_out(skip), .nmi_n_in(nmi_n),
      .fast_ext_irq_pin_in(pins), .stab_done_in(stab),
      .clk_freeze_out(frz), .osc_pll_stop_out(osc), .wdt_halt_out(wdt),
      .rc_discharge_out(rcd), .channel_irq_request_flag_out(flags),
      .irq_out(irq));
   pdec_rc_model #(.STAB_CYC(6)) rc_u (.clk_in(clk_in), .nrst_in(nrst_in),
      .rc_discharge_in(rcd), .stab_done_out(stab));
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic bus(logic w, logic [15:0] a, logic [31:0] d);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk_in);
      while (!(ack || err)) begin
         @(posedge clk_in);
      end
      rdat = wbdo;
      rd_err = err;
      cyc <= 0;
      stb <= 0;
      @(posedge clk_in);
   endtask : bus
   task automatic op(logic [31:0] w, logic es);
      vld <= 1;
      wrd <= w;
      #1 chk("skip", {31'h0, es}, {31'h0, skip});
      @(posedge clk_in);
      vld <= 0;
   endtask : op
   task automatic fin;
      done <= 1;
      @(posedge clk_in);
      done <= 0;
      #1 chk("frozen", 32'h0000_0003, {30'h0, osc, frz & wdt});
   endtask : fin
   task automatic do_reset;
      nrst_in <= 0;
      #1 chk("reset exit", 32'h0000_0000, {31'h0, frz});
      repeat (4) @(posedge clk_in);
      nrst_in <= 1;
      @(posedge clk_in);
   endtask : do_reset
   task automatic print_verdict;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge clk_in);
      do_reset();
      bus(0, PDEC_ADR_EDGE_SEL, 0);
      chk("edge_sel reset", 32'h0000_0000, rdat);
      bus(0, 16'hf1e0, 0);
      chk("unmapped err", 32'h0000_0001, {31'h0, rd_err});
      bus(1, PDEC_ADR_EDGE_SEL, 32'h0000_ff55);
      bus(0, PDEC_ADR_EDGE_SEL, 0);
      chk("edge_sel rw", 32'h0000_0055, rdat);
      op(PDEC_POWER_DOWN_INSTRUCTION_OP, 1);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      bus(1, PDEC_ADR_IRQ_MASK, 32'h0000_0004);
      chk("irq on", 32'h0000_0001, {31'h0, irq});
      bus(1, PDEC_ADR_IRQ_STAT, 32'h0000_0004);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      nmi_n <= 0;
      op(32'h1234_5678, 0);
      bus(0, PDEC_ADR_STATUS, 0);
      chk("state run", 32'h0000_0001, rdat);
      op(PDEC_POWER_DOWN_INSTRUCTION_OP, 0);
      bus(0, PDEC_ADR_STATUS, 0);
      chk("state drain", 32'h0000_0002, rdat);
      fin();
      pins <= 4'hf;
      repeat (20) @(posedge clk_in);
      chk("protected stays", 32'h0000_0001, {31'h0, frz});
      do_reset();
      bus(0, PDEC_ADR_EDGE_SEL, 0);
      chk("edge_sel default", 32'h0000_0000, rdat);
      bus(1, PDEC_ADR_SYSCFG, 32'h0000_0020);
      bus(1, PDEC_ADR_IRQ_MASK, 32'h0000_0002);
      for (int c = 1; c < 4; c++) begin
         ent = (c != 1);
         bus(1, PDEC_ADR_EDGE_SEL, c);
         pins <= {3'h0, !ent};
         @(posedge clk_in);
         if (c != 3) op(PDEC_POWER_DOWN_INSTRUCTION_OP, 1);
         pins <= {3'h0, ent};
         bus(1, PDEC_ADR_CHAN_CTL, 32'h0000_0f00);
         bus(1, PDEC_ADR_IRQ_STAT, 32'h0000_0007);
         op(PDEC_POWER_DOWN_INSTRUCTION_OP, 0);
         fin();
         pins <= {3'h0, !ent};
         n = 0;
         while (frz && n < 100) begin
            @(posedge clk_in);
            n++;
         end
         chk("woke", 32'h0000_0000, {31'h0, frz});
         chk("flag", 32'h0000_0001, {28'h0, flags});
         chk("wake irq", 32'h0000_0001, {31'h0, irq});
         bus(1, PDEC_ADR_IRQ_STAT, 32'h0000_0007);
         bus(1, PDEC_ADR_CHAN_CTL, 32'h0000_0f00);
         chk("flag clear", 32'h0000_0000, {28'h0, flags});
      end
      bus(1, PDEC_ADR_EDGE_SEL, 0);
      pins <= 4'h1;
      op(PDEC_POWER_DOWN_INSTRUCTION_OP, 0);
      fin();
      pins <= 4'h0;
      repeat (20) @(posedge clk_in);
      chk("code 00 no wake", 32'h0000_0001, {31'h0, frz});
      do_reset();
      print_verdict();
   end
endmodule : power_down_entry_exit_control_tb
bind pdec_ctrl pdec_ctrl_monitor mon_u (.clk_in, .nrst_in, .wb_cyc_in,
   .wb_stb_in, .wb_we_in, .wb_ack_out, .wb_err_out, .wb_adr_in,
   .instr_valid_in, .instr_done_in, .instr_skip_out, .instr_word_in,
   .stab_done_in, .clk_freeze_out, .osc_pll_stop_out, .wdt_halt_out,
   .rc_discharge_out, .channel_irq_request_flag_out);
`default_nettype wire
